// ---- core/pwmpdp_map.vh ----
// Register offsets, field positions and reset values of the PWM front end
`ifndef PWMPDP_MAP_VH
`define PWMPDP_MAP_VH
`define PWMPDP_CLKCTL_ADDR   8'h8E
`define PWMPDP_CH4H_ADDR     8'hC4
`define PWMPDP_CH5H_ADDR     8'hC5
`define PWMPDP_CH4L_ADDR     8'hCC
`define PWMPDP_CH5L_ADDR     8'hCD
`define PWMPDP_PERH_ADDR     8'hD1
`define PWMPDP_CH0H_ADDR     8'hD2
`define PWMPDP_CH1H_ADDR     8'hD3
`define PWMPDP_CH2H_ADDR     8'hD4
`define PWMPDP_CH3H_ADDR     8'hD5
`define PWMPDP_CTL0_ADDR     8'hD8
`define PWMPDP_PERL_ADDR     8'hD9
`define PWMPDP_CH0L_ADDR     8'hDA
`define PWMPDP_CH1L_ADDR     8'hDB
`define PWMPDP_CH2L_ADDR     8'hDC
`define PWMPDP_CH3L_ADDR     8'hDD
`define PWMPDP_MODE_ADDR     8'hDF
`define PWMPDP_SRC_BIT       6
`define PWMPDP_GROUP_BIT     5
`define PWMPDP_RUN_BIT       7
`define PWMPDP_LOAD_BIT      6
`define PWMPDP_CLR_BIT       4
`define PWMPDP_DIV_MSB       2
`define PWMPDP_DIV_LSB       0
`define PWMPDP_CLKCTL_MASK   8'h5A
`define PWMPDP_CTL0_MASK     8'hB0
`define PWMPDP_RESET_BYTE    8'h00
`define PWMPDP_RESET_WORD    16'h0000
`endif

// ---- core/pwmpdp_duty_mem.v ----
// Storage for the six written duty values, two bytes each, with registered read port
`timescale 1ns/100ps
`default_nettype none
module pwmpdp_duty_mem (
	input  wire        ref_clk,
	input  wire        nrst,
	input  wire        wr_en,
	input  wire [3:0]  wr_idx,
	input  wire [7:0]  wr_data,
	input  wire [3:0]  rd_idx,
	output reg  [7:0]  rd_data,
	output wire [95:0] duty_flat
);
`include "pwmpdp_map.vh"
	reg [7:0] mem_reg [0:11];
	integer i;
	genvar g;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (i = 0; i < 12; i = i + 1) begin
				mem_reg[i] <= `PWMPDP_RESET_BYTE;
			end
			rd_data <= `PWMPDP_RESET_BYTE;
		end else begin
			// Writes land even in group mode so they apply once it is cleared
			if (wr_en && wr_idx < 4'hC) begin
				mem_reg[wr_idx] <= wr_data;
			end
			rd_data <= (rd_idx < 4'hC) ? mem_reg[rd_idx] : `PWMPDP_RESET_BYTE;
		end
	end
	// Index 2n is the low byte of channel n, 2n+1 its high byte
	generate
		for (g = 0; g < 6; g = g + 1) begin : flat_g
			assign duty_flat[16*g+15:16*g] = {mem_reg[2*g+1], mem_reg[2*g]};
		end
	endgenerate
endmodule
`default_nettype wire

// ---- core/pwmpdp_top.v ----
// Register front end, prescaler, period counter and six edge-aligned generators
`timescale 1ns/100ps
`default_nettype none
module pwmpdp_top (
	input  wire       ref_clk,
	input  wire       nrst,
	input  wire       sfr_wr,
	input  wire       sfr_rd,
	input  wire [7:0] sfr_addr,
	input  wire [7:0] sfr_wdata,
	input  wire       sfr_page1,
	input  wire       timer1_overflow,
	output reg  [7:0] sfr_rdata,
	output reg        sfr_hit,
	output reg        prescale_tick,
	output reg        reload_request,
	output reg  [5:0] generator_out
);
`include "pwmpdp_map.vh"
	localparam [3:0] ST_IDLE = 4'b0001;
	localparam [3:0] ST_RUN  = 4'b0010;
	localparam [3:0] ST_WRAP = 4'b0100;
	localparam [3:0] ST_CLR  = 4'b1000;

	reg  [7:0]  clock_source_control_reg;
	reg  [7:0]  waveform_mode_control_reg;
	reg  [7:0]  run_control_reg;
	reg  [15:0] period_value_reg;
	reg  [15:0] period_active_reg;
	reg  [95:0] duty_active_reg;
	reg  [15:0] count_reg;
	reg  [15:0] count_next;
	reg  [6:0]  div_count_reg;
	reg  [3:0]  state_reg;
	reg  [3:0]  state_next;
	reg         rd_pend_reg;
	reg         rd_mem_reg;
	reg  [7:0]  rd_direct_reg;
	reg  [5:0]  gen_next;
	integer     k;

	wire        clock_source_select   = clock_source_control_reg[`PWMPDP_SRC_BIT];
	wire        group_duty_mode       = waveform_mode_control_reg[`PWMPDP_GROUP_BIT];
	wire [2:0]  clock_prescale_select = waveform_mode_control_reg[`PWMPDP_DIV_MSB:`PWMPDP_DIV_LSB];
	wire        run_enable            = run_control_reg[`PWMPDP_RUN_BIT];
	wire        clear_request         = run_control_reg[`PWMPDP_CLR_BIT];
	wire [95:0] duty_flat;
	wire [7:0]  mem_rdata;

	// Maps a bus address on the current page to a duty byte index; 4'hF means no duty byte
	function [3:0] duty_index;
		input [7:0] addr;
		input       page1;
		begin
			duty_index = 4'hF;
			if (page1 && addr == `PWMPDP_CH4L_ADDR) begin
				duty_index = 4'h8;
			end else if (page1 && addr == `PWMPDP_CH4H_ADDR) begin
				duty_index = 4'h9;
			end else if (page1 && addr == `PWMPDP_CH5L_ADDR) begin
				duty_index = 4'hA;
			end else if (page1 && addr == `PWMPDP_CH5H_ADDR) begin
				duty_index = 4'hB;
			end else if (!page1 && addr == `PWMPDP_CH0L_ADDR) begin
				duty_index = 4'h0;
			end else if (!page1 && addr == `PWMPDP_CH0H_ADDR) begin
				duty_index = 4'h1;
			end else if (!page1 && addr == `PWMPDP_CH1L_ADDR) begin
				duty_index = 4'h2;
			end else if (!page1 && addr == `PWMPDP_CH1H_ADDR) begin
				duty_index = 4'h3;
			end else if (!page1 && addr == `PWMPDP_CH2L_ADDR) begin
				duty_index = 4'h4;
			end else if (!page1 && addr == `PWMPDP_CH2H_ADDR) begin
				duty_index = 4'h5;
			end else if (!page1 && addr == `PWMPDP_CH3L_ADDR) begin
				duty_index = 4'h6;
			end else if (!page1 && addr == `PWMPDP_CH3H_ADDR) begin
				duty_index = 4'h7;
			end
		end
	endfunction

	// Selects the compare value for one channel, honouring group mode
	function [15:0] pick_duty;
		input [95:0] duty;
		input [2:0]  ch;
		input        grp;
		begin
			if (grp) begin
				pick_duty = ch[0] ? duty[31:16] : duty[15:0];
			end else begin
				case (ch)
					3'd0:    pick_duty = duty[15:0];
					3'd1:    pick_duty = duty[31:16];
					3'd2:    pick_duty = duty[47:32];
					3'd3:    pick_duty = duty[63:48];
					3'd4:    pick_duty = duty[79:64];
					default: pick_duty = duty[95:80];
				endcase
			end
		end
	endfunction

	wire [3:0] wr_idx  = duty_index(sfr_addr, sfr_page1);
	wire       dir_wr  = sfr_wr && !sfr_page1;

	pwmpdp_duty_mem pwmpdp_duty_mem_i (
		.ref_clk   (ref_clk),
		.nrst      (nrst),
		.wr_en     (sfr_wr && wr_idx != 4'hF),
		.wr_idx    (wr_idx),
		.wr_data   (sfr_wdata),
		.rd_idx    (wr_idx),
		.rd_data   (mem_rdata),
		.duty_flat (duty_flat)
	);

	// Prescale code to counter mask: code n divides by 2 to the n
	function [6:0] prescale_mask;
		input [2:0] code;
		begin
			case (code)
				3'h0:    prescale_mask = 7'h00;
				3'h1:    prescale_mask = 7'h01;
				3'h2:    prescale_mask = 7'h03;
				3'h3:    prescale_mask = 7'h07;
				3'h4:    prescale_mask = 7'h0F;
				3'h5:    prescale_mask = 7'h1F;
				3'h6:    prescale_mask = 7'h3F;
				default: prescale_mask = 7'h7F;
			endcase
		end
	endfunction

	// Prescaler: the source event is every system clock or every timer 1 overflow
	wire       src_event = clock_source_select ? timer1_overflow : 1'b1;
	wire [6:0] div_mask  = prescale_mask(clock_prescale_select);
	wire       div_wrap  = (div_count_reg & div_mask) == div_mask;
	wire       tick_now  = run_enable && src_event && div_wrap;

	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			div_count_reg <= 7'h00;
		end else if (!run_enable) begin
			div_count_reg <= 7'h00;
		end else if (src_event) begin
			div_count_reg <= div_wrap ? 7'h00 : div_count_reg + 7'h01;
		end
	end

	// Counter control
	wire period_end = tick_now && count_reg >= period_active_reg;
	always @* begin
		state_next = state_reg;
		count_next = count_reg;
		case (state_reg)
			ST_IDLE: begin
				if (clear_request) begin
					state_next = ST_CLR;
				end else if (run_enable) begin
					state_next = ST_RUN;
				end
			end
			ST_RUN: begin
				if (clear_request) begin
					state_next = ST_CLR;
				end else if (!run_enable) begin
					state_next = ST_IDLE;
				end else if (period_end) begin
					state_next = ST_WRAP;
					count_next = `PWMPDP_RESET_WORD;
				end else if (tick_now) begin
					count_next = count_reg + 16'h0001;
				end
			end
			ST_WRAP: begin
				state_next = run_enable ? ST_RUN : ST_IDLE;
				if (tick_now) begin
					count_next = count_reg + 16'h0001;
				end
			end
			// Clear parks the counter at zero; a later run resumes from there
			ST_CLR: begin
				count_next = `PWMPDP_RESET_WORD;
				state_next = ST_IDLE;
			end
			default: begin
				count_next = `PWMPDP_RESET_WORD;
				state_next = ST_IDLE;
			end
		endcase
	end

	// Software-visible configuration registers
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			clock_source_control_reg  <= `PWMPDP_RESET_BYTE;
			waveform_mode_control_reg <= `PWMPDP_RESET_BYTE;
		end else begin
			if (dir_wr && sfr_addr == `PWMPDP_CLKCTL_ADDR) begin
				clock_source_control_reg <= sfr_wdata & `PWMPDP_CLKCTL_MASK;
			end
			if (dir_wr && sfr_addr == `PWMPDP_MODE_ADDR) begin
				waveform_mode_control_reg <= sfr_wdata;
			end
		end
	end

	// Period bytes are independent; with no byte latch either order of writes works
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			period_value_reg <= `PWMPDP_RESET_WORD;
		end else begin
			if (dir_wr && sfr_addr == `PWMPDP_PERL_ADDR) begin
				period_value_reg[7:0] <= sfr_wdata;
			end
			if (dir_wr && sfr_addr == `PWMPDP_PERH_ADDR) begin
				period_value_reg[15:8] <= sfr_wdata;
			end
		end
	end

	// Control 0: a software set of load or clear wins over the hardware clear in the same cycle
	wire        ctl0_wr   = dir_wr && sfr_addr == `PWMPDP_CTL0_ADDR;
	wire        load_set  = ctl0_wr && sfr_wdata[`PWMPDP_LOAD_BIT];
	wire        clr_set   = ctl0_wr && sfr_wdata[`PWMPDP_CLR_BIT];
	wire        load_done = state_reg == ST_WRAP && run_control_reg[`PWMPDP_LOAD_BIT];
	wire        clr_done  = state_reg == ST_CLR;
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			run_control_reg <= `PWMPDP_RESET_BYTE;
		end else begin
			if (ctl0_wr) begin
				run_control_reg <= sfr_wdata & `PWMPDP_CTL0_MASK;
			end
			if (load_set) begin
				run_control_reg[`PWMPDP_LOAD_BIT] <= 1'b1;
			end else if (load_done) begin
				run_control_reg[`PWMPDP_LOAD_BIT] <= 1'b0;
			end else begin
				run_control_reg[`PWMPDP_LOAD_BIT] <= run_control_reg[`PWMPDP_LOAD_BIT];
			end
			if (clr_set) begin
				run_control_reg[`PWMPDP_CLR_BIT] <= 1'b1;
			end else if (clr_done) begin
				run_control_reg[`PWMPDP_CLR_BIT] <= 1'b0;
			end else begin
				run_control_reg[`PWMPDP_CLR_BIT] <= run_control_reg[`PWMPDP_CLR_BIT];
			end
		end
	end

	// Shadow copies only change at a completed period, so a half-written value never shows
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			period_active_reg <= `PWMPDP_RESET_WORD;
			duty_active_reg   <= 96'h0;
		end else if (load_done) begin
			period_active_reg <= period_value_reg;
			duty_active_reg   <= duty_flat;
		end
	end

	// Counter, tick and generator outputs
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			count_reg      <= `PWMPDP_RESET_WORD;
			state_reg      <= ST_IDLE;
			generator_out  <= 6'h00;
			prescale_tick  <= 1'b0;
			reload_request <= 1'b0;
		end else begin
			state_reg      <= state_next;
			count_reg      <= count_next;
			prescale_tick  <= tick_now;
			reload_request <= run_control_reg[`PWMPDP_LOAD_BIT];
			if (state_reg == ST_IDLE || state_reg == ST_CLR) begin
				generator_out <= 6'h00;
			end else begin
				generator_out <= gen_next;
			end
		end
	end

	// Set at count zero, cleared on duty match
	always @* begin
		for (k = 0; k < 6; k = k + 1) begin
			if (count_next == pick_duty(duty_active_reg, k[2:0], group_duty_mode)) begin
				gen_next[k] = 1'b0;
			end else if (count_next == `PWMPDP_RESET_WORD) begin
				gen_next[k] = 1'b1;
			end else begin
				gen_next[k] = generator_out[k];
			end
		end
	end

	// Read path: one cycle latency so the memory's registered data line up
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rd_pend_reg   <= 1'b0;
			rd_mem_reg    <= 1'b0;
			rd_direct_reg <= `PWMPDP_RESET_BYTE;
		end else begin
			rd_pend_reg   <= sfr_rd;
			rd_mem_reg    <= wr_idx != 4'hF;
			rd_direct_reg <= `PWMPDP_RESET_BYTE;
			if (!sfr_page1 && sfr_addr == `PWMPDP_CLKCTL_ADDR) begin
				rd_direct_reg <= clock_source_control_reg;
			end else if (!sfr_page1 && sfr_addr == `PWMPDP_MODE_ADDR) begin
				rd_direct_reg <= waveform_mode_control_reg;
			end else if (!sfr_page1 && sfr_addr == `PWMPDP_CTL0_ADDR) begin
				rd_direct_reg <= run_control_reg;
			end else if (!sfr_page1 && sfr_addr == `PWMPDP_PERL_ADDR) begin
				rd_direct_reg <= period_value_reg[7:0];
			end else if (!sfr_page1 && sfr_addr == `PWMPDP_PERH_ADDR) begin
				rd_direct_reg <= period_value_reg[15:8];
			end
		end
	end

	// Read data stand for one cycle with the answer and are zero otherwise
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			sfr_rdata <= `PWMPDP_RESET_BYTE;
			sfr_hit   <= 1'b0;
		end else begin
			sfr_hit   <= rd_pend_reg;
			sfr_rdata <= rd_pend_reg ? (rd_mem_reg ? mem_rdata : rd_direct_reg) : `PWMPDP_RESET_BYTE;
		end
	end
endmodule
`default_nettype wire

// ---- testbench/pwmpdp_sva.sv ----
// Port checker for the PWM front end
`timescale 1ns/100ps
`default_nettype none
module pwmpdp_sva (
	input wire logic       ref_clk,
	input wire logic       nrst,
	input wire logic       sfr_wr,
	input wire logic       sfr_rd,
	input wire logic [7:0] sfr_addr,
	input wire logic [7:0] sfr_wdata,
	input wire logic       sfr_page1,
	input wire logic       timer1_overflow,
	input wire logic [7:0] sfr_rdata,
	input wire logic       sfr_hit,
	input wire logic       prescale_tick,
	input wire logic       reload_request,
	input wire logic [5:0] generator_out
);
	logic       run_q;
	logic       src_q;
	logic       grp_ok;
	logic       grp_q;
	logic       rr_q;
	logic [2:0] div_q;
	wire        wd = sfr_wr && !sfr_page1;
	// Mirror of software settings; group check waits for a reload so old shadows cannot trip it
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			run_q <= 1'b0;
			src_q <= 1'b0;
			div_q <= 3'h0;
			grp_ok <= 1'b0;
			grp_q <= 1'b0;
			rr_q <= 1'b0;
		end else begin
			rr_q <= reload_request;
			if (wd && sfr_addr == 8'hD8)
				run_q <= sfr_wdata[7];
			if (wd && sfr_addr == 8'h8E)
				src_q <= sfr_wdata[6];
			if (wd && sfr_addr == 8'hDF)
				div_q <= sfr_wdata[2:0];
			if (wd && sfr_addr == 8'hDF) begin
				grp_q <= sfr_wdata[5];
				if (!sfr_wdata[5])
					grp_ok <= 1'b0;
			end else if (rr_q && !reload_request && grp_q)
				grp_ok <= 1'b1;
		end
	end
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_hit_after_rd; sfr_rd |-> ##2 sfr_hit; endproperty
	a_hit_after_rd: assert property (p_hit_after_rd)
		else $error("read not answered");
	property p_hit_cause; sfr_hit |-> $past(sfr_rd, 2); endproperty
	a_hit_cause: assert property (p_hit_cause)
		else $error("answer without read");
	property p_rdata_idle; !sfr_hit |-> sfr_rdata == 8'h00; endproperty
	a_rdata_idle: assert property (p_rdata_idle)
		else $error("read data outside answer");
	property p_quiet; !$past(nrst) |-> generator_out == 6'h00 && !reload_request && !prescale_tick; endproperty
	a_quiet: assert property (p_quiet)
		else $error("outputs active after reset");
	property p_tick_run; prescale_tick |-> $past(run_q) || $past(run_q, 2); endproperty
	a_tick_run: assert property (p_tick_run)
		else $error("tick while stopped");
	property p_tick_src; prescale_tick && src_q && $past(src_q, 2) |-> $past(timer1_overflow) || $past(timer1_overflow, 2); endproperty
	a_tick_src: assert property (p_tick_src)
		else $error("tick without overflow");
	property p_div_gap; prescale_tick && div_q == 3'h2 && !src_q |=> !prescale_tick [*3]; endproperty
	a_div_gap: assert property (p_div_gap)
		else $error("ticks too close");
	property p_reload_cause; $rose(reload_request) |-> $past(wd && sfr_addr == 8'hD8 && sfr_wdata[6], 2); endproperty
	a_reload_cause: assert property (p_reload_cause)
		else $error("reload without request");
	property p_group; grp_ok |-> {generator_out[4], generator_out[2]} == {2{generator_out[0]}}
		&& {generator_out[5], generator_out[3]} == {2{generator_out[1]}}; endproperty
	a_group: assert property (p_group)
		else $error("group outputs differ");
endmodule
bind pwmpdp_top pwmpdp_sva pwmpdp_sva_i (.ref_clk(ref_clk), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
	.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_page1(sfr_page1), .timer1_overflow(timer1_overflow),
	.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .prescale_tick(prescale_tick),
	.reload_request(reload_request), .generator_out(generator_out));
`default_nettype wire

// ---- testbench/pwmpdp_tb_top.sv ----
// Testbench for the PWM front end
`timescale 1ns/100ps
`default_nettype none
module pwmpdp_tb_top;
	logic        ref_clk = 0, nrst = 0, sfr_wr = 0, sfr_rd = 0, sfr_page1 = 0, timer1_overflow = 0;
	logic [7:0]  sfr_addr = 0, sfr_wdata = 0, sfr_rdata;
	logic        sfr_hit, prescale_tick, reload_request;
	logic [5:0]  generator_out;
	logic [1:0]  oc = 0;
	int          fails = 0, total_checks = 0, cyc = 0, cnt[6];
	logic [7:0]  rmap[16] = '{8'h8E, 8'hC4, 8'hC5, 8'hCC, 8'hCD, 8'hD1, 8'hD2, 8'hD3,
	                         8'hD4, 8'hD5, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDF};
	logic [7:0]  lo[6] = '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hCC, 8'hCD};
	logic [7:0]  hi[6] = '{8'hD2, 8'hD3, 8'hD4, 8'hD5, 8'hC4, 8'hC5};
	logic [15:0] duty[6] = '{16'h0003, 16'h0006, 16'h0001, 16'h0002, 16'h0004, 16'h0008};
	pwmpdp_top pwmpdp_top_i (.ref_clk(ref_clk), .nrst(nrst), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
		.sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_page1(sfr_page1), .timer1_overflow(timer1_overflow),
		.sfr_rdata(sfr_rdata), .sfr_hit(sfr_hit), .prescale_tick(prescale_tick),
		.reload_request(reload_request), .generator_out(generator_out));
	always #25 ref_clk = ~ref_clk;
	// Overflow every third cycle runs always, so system-clock mode must ignore it
	always @(posedge ref_clk) begin
		oc <= (oc == 2'h2) ? 2'h0 : oc + 2'h1;
		timer1_overflow <= (oc == 2'h2);
		cyc <= cyc + 1;
		if (cyc > 30000) begin
			fails = fails + 1;
			give_verdict;
		end
	end
	task give_verdict;
		if (fails == 0 && total_checks > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task chk(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			fails++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		sfr_page1 <= (a[7:4] == 4'hC);
		@(posedge ref_clk);
		sfr_wr <= 1'b0;
	endtask
	// Page is passed apart so that a wrong-page access can be made
	task rd(input logic [7:0] a, input logic p, input logic [7:0] e);
		int i;
		@(posedge ref_clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		sfr_page1 <= p;
		@(posedge ref_clk);
		sfr_rd <= 1'b0;
		for (i = 0; i < 4 && sfr_hit !== 1'b1; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk({15'h0, sfr_hit}, 16'h0001);
		chk({8'h00, sfr_rdata}, {8'h00, e});
	endtask
	task go(input logic [7:0] ck, input logic [7:0] md);
		int i;
		wr(8'hD8, 8'h10);
		wr(8'h8E, ck);
		wr(8'hDF, md);
		wr(8'hD8, 8'hC0);
		repeat (3) @(posedge ref_clk);
		#1;
		for (i = 0; i < 3000 && reload_request !== 1'b0; i++) begin
			@(posedge ref_clk);
			#1;
		end
		repeat (64) @(posedge ref_clk);
	endtask
	// Whole periods only, so high time is exact whatever the phase
	task meas(input int n, input int m, input logic g);
		int k;
		for (k = 0; k < 6; k++)
			cnt[k] = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			for (k = 0; k < 6; k++)
				cnt[k] += generator_out[k];
		end
		for (k = 0; k < 6; k++)
			chk(cnt[k][15:0], 16'(m * duty[g ? (k & 1) : k]));
	endtask
	initial begin
		int i;
		repeat (2) @(posedge ref_clk);
		nrst <= 1'b1;
		for (i = 0; i < 16; i++)
			rd(rmap[i], rmap[i][7:4] == 4'hC, 8'h00);
		for (i = 0; i < 16; i++)
			wr(rmap[i], 8'h3C ^ i[7:0]);
		for (i = 0; i < 16; i++)
			rd(rmap[i], rmap[i][7:4] == 4'hC, (8'h3C ^ i[7:0]) & (i == 0 ? 8'h5A : 8'hFF));
		rd(8'hC4, 1'b0, 8'h00);
		rd(8'hD0, 1'b0, 8'h00);
		wr(8'hD1, 8'h00);
		wr(8'hD9, 8'h09);
		for (i = 0; i < 6; i++) begin
			wr(hi[i], 8'h00);
			wr(lo[i], duty[i][7:0]);
		end
		go(8'h00, 8'h00);
		meas(40, 4, 1'b0);
		go(8'h00, 8'h02);
		meas(80, 8, 1'b0);
		go(8'h40, 8'h00);
		meas(60, 6, 1'b0);
		go(8'h00, 8'h20);
		meas(40, 4, 1'b1);
		wr(8'hDC, 8'h05);
		duty[2] = 16'h0005;
		meas(40, 4, 1'b1);
		rd(8'hDC, 1'b0, 8'h05);
		go(8'h00, 8'h00);
		meas(40, 4, 1'b0);
		rd(8'hD8, 1'b0, 8'h80);
		wr(8'hD9, 8'h13);
		meas(40, 4, 1'b0);
		go(8'h00, 8'h00);
		meas(40, 2, 1'b0);
		give_verdict;
	end
endmodule
`default_nettype wire
